// [rtl/prc_defines.vh]
// Function
// - A rail's discharge field is forced to 00 while that rail is enabled.
// - Discharge codes: 00 none, 01 100 ohm, 10 200 ohm, 11 500 ohm.
// - Discharge A holds rails four, three, two, one at 7:6, 5:4, 3:2, 1:0.
// - Discharge B holds linear two, switch A1, rail six, rail five.
// - Discharge C holds switch B2, B1, linear three; top two bits read zero.
// - Output-three delay codes 000..111 give 2.5 ms up to 100 ms.
// - Delay starts once all grouped rails regulate; power-good on expiry.
// - Host-driven output three without termination use ignores the delay.
// - Writing one to shutdown bit 0 resets the device and all registers.
// - The shutdown bit clears itself and never reads back as one.
// - The shutdown write gets no acknowledge; the host expects that.
// - Shutdown register resets to zero; only bit 0 is writable.
// - Rail one and two sleep registers: code at 7:1, enable at bit 0.
// - Sleep enabled and sleep pin low selects sleep code, else normal.
// - Each rail's sleep pin is chosen by factory configuration only.
// - Rail four and five voltage registers: code at 7:1, decay at bit 0.
// - Decay zero slews actively down; decay one decays passively.
// - Rail four sleep register: code at 7:1, bit 0 reads zero.
`ifndef PRC_DEFINES_VH
`define PRC_DEFINES_VH

`define PRC_OFS_DISCH_A     8'h40
`define PRC_OFS_DISCH_B     8'h41
`define PRC_OFS_DISCH_C     8'h42
`define PRC_OFS_GOOD_DELAY  8'h43
`define PRC_OFS_SHUTDOWN    8'h91
`define PRC_OFS_R1_SLEEP    8'h92
`define PRC_OFS_R2_SLEEP    8'h93
`define PRC_OFS_R4_VOLT     8'h94
`define PRC_OFS_R4_SLEEP    8'h95
`define PRC_OFS_R5_VOLT     8'h96

`define PRC_MASK_DISCH_C    8'h3f
`define PRC_MASK_GOOD_DELAY 8'h07
`define PRC_MASK_R4_SLEEP   8'hfe
`define PRC_MASK_FULL       8'hff
`define PRC_SHUTDOWN_RESET  8'h00
`define PRC_SHUTDOWN_BIT    0
`define PRC_SLEEP_EN_BIT    0
`define PRC_DECAY_BIT       0
`define PRC_DISCH_NONE      2'h0

`define PRC_CLK_PERIOD_NS   10
`define PRC_TICK_NS         2500000
`define PRC_DLY_T0          6'h01
`define PRC_DLY_T1          6'h02
`define PRC_DLY_T2          6'h04
`define PRC_DLY_T3          6'h06
`define PRC_DLY_T4          6'h08
`define PRC_DLY_T5          6'h14
`define PRC_DLY_T6          6'h1e
`define PRC_DLY_T7          6'h28

`endif

// [rtl/prc_rail_regs.v]
`timescale 1ns/1ns
`include "prc_defines.vh"

module prc_rail_regs #(
   parameter [6:0]  DEV_ADDR    = 7'h2a,
   parameter [31:0] TICK_CYCLES = `PRC_TICK_NS / `PRC_CLK_PERIOD_NS
) (
   input  wire        core_clk_i,
   input  wire        rst_i,
   input  wire        scl_i,
   input  wire        sda_i,
   output reg         sda_o,
   output reg         sda_oe_o,
   input  wire [71:0] otp_image_i,
   input  wire [1:0]  otp_sleep_pin_sel_i,
   input  wire        otp_out3_pg_mode_i,
   input  wire        otp_out3_vtt_use_i,
   input  wire [11:0] rail_enabled_i,
   input  wire        out3_rails_in_reg_i,
   input  wire        sleep_pin_first_i,
   input  wire        sleep_pin_second_i,
   input  wire        general_output_three_host_level_i,
   input  wire [6:0]  rail1_normal_code_i,
   input  wire [6:0]  rail2_normal_code_i,
   output wire [21:0] discharge_select_o,
   output reg         general_output_three_o,
   output reg         termination_enable_o,
   output reg         shutdown_trigger_o,
   output reg  [6:0]  rail1_target_code_o,
   output reg  [6:0]  rail2_target_code_o,
   output wire [6:0]  rail4_normal_code_o,
   output wire [6:0]  rail4_sleep_code_o,
   output wire        rail4_passive_decay_o,
   output wire [6:0]  rail5_normal_code_o,
   output wire        rail5_passive_decay_o
);

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_REG  = 3'h2;
   localparam [2:0] S_WDAT = 3'h3;
   localparam [2:0] S_RDAT = 3'h4;
   localparam       NSYNC  = 17;

   reg  [7:0]       rf_reg [0:8];
   reg  [NSYNC-1:0] sync1_reg;
   reg  [NSYNC-1:0] sync2_reg;
   reg              sda_d_reg;
   reg              scl_d_reg;
   reg  [2:0]       st_reg;
   reg  [3:0]       cnt_reg;
   reg  [7:0]       shift_reg;
   reg  [7:0]       tx_reg;
   reg  [7:0]       ptr_reg;
   reg              nack_reg;
   reg              wr_reg;
   reg  [7:0]       wr_data_reg;
   reg              reload_reg;
   reg  [31:0]      presc_reg;
   reg  [5:0]       ticks_reg;
   reg              good_reg;
   reg  [5:0]       target_next;
   reg  [3:0]       wr_idx_next;
   reg  [7:0]       rd_next;
   integer          i;

   wire [11:0] rail_en_s  = sync2_reg[11:0];
   wire        in_reg_s   = sync2_reg[12];
   wire        pin1_s     = sync2_reg[13];
   wire        pin2_s     = sync2_reg[14];
   wire        sda_s      = sync2_reg[15];
   wire        scl_s      = sync2_reg[16];
   wire        scl_rise   = scl_s & ~scl_d_reg;
   wire        scl_fall   = ~scl_s & scl_d_reg;
   wire        start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire        stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // Bus pins, sleep pins, rail enables and regulation status pass two flops before anything reads them.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         // Bus pins reset to their idle high level so no false edge follows.
         sync1_reg <= {2'b11, {(NSYNC-2){1'b0}}};
         sync2_reg <= {2'b11, {(NSYNC-2){1'b0}}};
         sda_d_reg <= 1'b1;
         scl_d_reg <= 1'b1;
      end else begin
         sync1_reg <= {scl_i, sda_i, sleep_pin_second_i, sleep_pin_first_i,
                       out3_rails_in_reg_i, rail_enabled_i};
         sync2_reg <= sync1_reg;
         sda_d_reg <= sda_s;
         scl_d_reg <= scl_s;
      end
   end

   // Map a bus offset to a storage slot; slot 15 means no storage.
   always @* begin
      case (ptr_reg)
         `PRC_OFS_DISCH_A:    wr_idx_next = 4'h0;
         `PRC_OFS_DISCH_B:    wr_idx_next = 4'h1;
         `PRC_OFS_DISCH_C:    wr_idx_next = 4'h2;
         `PRC_OFS_GOOD_DELAY: wr_idx_next = 4'h3;
         `PRC_OFS_R1_SLEEP:   wr_idx_next = 4'h4;
         `PRC_OFS_R2_SLEEP:   wr_idx_next = 4'h5;
         `PRC_OFS_R4_VOLT:    wr_idx_next = 4'h6;
         `PRC_OFS_R4_SLEEP:   wr_idx_next = 4'h7;
         `PRC_OFS_R5_VOLT:    wr_idx_next = 4'h8;
         default:             wr_idx_next = 4'hf;
      endcase
      if (wr_idx_next == 4'hf)
         rd_next = `PRC_SHUTDOWN_RESET; // Shutdown and holes read zero.
      else
         rd_next = rf_reg[wr_idx_next];
   end

   // Two-wire slave; it answers on falling clock edges and samples on rising.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         st_reg             <= S_IDLE;
         cnt_reg            <= 4'h0;
         shift_reg          <= 8'h00;
         tx_reg             <= 8'h00;
         ptr_reg            <= 8'h00;
         nack_reg           <= 1'b1;
         wr_reg             <= 1'b0;
         wr_data_reg        <= 8'h00;
         sda_o              <= 1'b0;
         sda_oe_o           <= 1'b0;
         shutdown_trigger_o <= 1'b0;
      end else begin
         wr_reg             <= 1'b0;
         shutdown_trigger_o <= 1'b0;
         if (start_cond) begin
            st_reg   <= S_ADDR;
            // The clock fall that closes the start wraps this to zero.
            cnt_reg  <= 4'hf;
            sda_oe_o <= 1'b0;
         end else if (stop_cond) begin
            st_reg   <= S_IDLE;
            sda_oe_o <= 1'b0;
         end else if (st_reg != S_IDLE && scl_rise) begin
            if (cnt_reg == 4'h8)
               nack_reg <= sda_s;
            else
               shift_reg <= {shift_reg[6:0], sda_s};
         end else if (st_reg != S_IDLE && scl_fall) begin
            if (cnt_reg == 4'h8) begin
               cnt_reg  <= 4'h0;
               sda_oe_o <= 1'b0;
               if (st_reg == S_RDAT) begin
                  if (nack_reg) begin
                     st_reg <= S_IDLE;
                  end else begin
                     sda_oe_o <= ~rd_next[7];
                     tx_reg   <= {rd_next[6:0], 1'b0};
                     ptr_reg  <= ptr_reg + 8'h01;
                  end
               end
            end else if (cnt_reg == 4'h7) begin
               cnt_reg <= 4'h8;
               case (st_reg)
                  S_ADDR: begin
                     if (shift_reg[7:1] == DEV_ADDR) begin
                        sda_oe_o <= 1'b1;
                        st_reg   <= shift_reg[0] ? S_RDAT : S_REG;
                     end else begin
                        st_reg <= S_IDLE;
                     end
                  end
                  S_REG: begin
                     ptr_reg  <= shift_reg;
                     sda_oe_o <= 1'b1;
                     st_reg   <= S_WDAT;
                  end
                  S_WDAT: begin
                     if (ptr_reg == `PRC_OFS_SHUTDOWN &&
                         shift_reg[`PRC_SHUTDOWN_BIT]) begin
                        shutdown_trigger_o <= 1'b1;
                        st_reg             <= S_IDLE; // No acknowledge.
                     end else begin
                        wr_reg      <= 1'b1;
                        wr_data_reg <= shift_reg;
                        sda_oe_o    <= 1'b1;
                        ptr_reg     <= ptr_reg + 8'h01;
                     end
                  end
                  default: sda_oe_o <= 1'b0; // Release for the host's ack.
               endcase
            end else begin
               cnt_reg <= cnt_reg + 4'h1;
               if (st_reg == S_RDAT) begin
                  sda_oe_o <= ~tx_reg[7];
                  tx_reg   <= {tx_reg[6:0], 1'b0};
               end
            end
         end
      end
   end

   // Reload from the factory image after reset and after shutdown.
   always @(posedge core_clk_i) begin
      if (rst_i)
         reload_reg <= 1'b1;
      else
         reload_reg <= shutdown_trigger_o;
   end

   // Register file. The write hits the slot of the pointer before increment,
   // so the slot is taken one cycle late from a saved copy of the pointer.
   reg [3:0] wslot_reg;
   always @(posedge core_clk_i) begin
      if (rst_i)
         wslot_reg <= 4'hf;
      else if (st_reg == S_WDAT && scl_fall && cnt_reg == 4'h7)
         wslot_reg <= wr_idx_next;
   end

   always @(posedge core_clk_i) begin
      if (reload_reg) begin
         for (i = 0; i < 9; i = i + 1)
            rf_reg[i] <= otp_image_i[8*i +: 8];
         rf_reg[2] <= otp_image_i[23:16] & `PRC_MASK_DISCH_C;
         rf_reg[3] <= otp_image_i[31:24] & `PRC_MASK_GOOD_DELAY;
         rf_reg[7] <= otp_image_i[63:56] & `PRC_MASK_R4_SLEEP;
      end else begin
         if (wr_reg) begin
            case (wslot_reg)
               4'h2: rf_reg[2] <= wr_data_reg & `PRC_MASK_DISCH_C;
               4'h3: rf_reg[3] <= wr_data_reg & `PRC_MASK_GOOD_DELAY;
               4'h7: rf_reg[7] <= wr_data_reg & `PRC_MASK_R4_SLEEP;
               4'hf: rf_reg[0] <= rf_reg[0]; // Unmapped or shutdown.
               default: rf_reg[wslot_reg] <= wr_data_reg;
            endcase
         end
         // An enabled rail's field is held at no-discharge over any write.
         for (i = 0; i < 11; i = i + 1)
            if (rail_en_s[i])
               rf_reg[i/4][2*(i%4) +: 2] <= `PRC_DISCH_NONE;
         if (rail_en_s[11])
            rf_reg[2][5:4] <= `PRC_DISCH_NONE;
      end
   end

   // Discharge pull-down codes go to the analog side as stored.
   assign discharge_select_o = {rf_reg[2][5:0], rf_reg[1], rf_reg[0]};
   // Decay bits tell the converter to let the output fall passively.
   assign rail4_normal_code_o   = rf_reg[6][7:1];
   assign rail4_passive_decay_o = rf_reg[6][`PRC_DECAY_BIT];
   assign rail4_sleep_code_o    = rf_reg[7][7:1];
   assign rail5_normal_code_o   = rf_reg[8][7:1];
   assign rail5_passive_decay_o = rf_reg[8][`PRC_DECAY_BIT];

   // Sleep code applies only while enabled and the factory-chosen pin is low.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         rail1_target_code_o <= 7'h00;
         rail2_target_code_o <= 7'h00;
      end else begin
         if (rf_reg[4][`PRC_SLEEP_EN_BIT] &&
             !(otp_sleep_pin_sel_i[0] ? pin2_s : pin1_s))
            rail1_target_code_o <= rf_reg[4][7:1];
         else
            rail1_target_code_o <= rail1_normal_code_i;
         if (rf_reg[5][`PRC_SLEEP_EN_BIT] &&
             !(otp_sleep_pin_sel_i[1] ? pin2_s : pin1_s))
            rail2_target_code_o <= rf_reg[5][7:1];
         else
            rail2_target_code_o <= rail2_normal_code_i;
      end
   end

   // Delay code to a count of 2.5 ms ticks.
   always @* begin
      case (rf_reg[3][2:0])
         3'h0:    target_next = `PRC_DLY_T0;
         3'h1:    target_next = `PRC_DLY_T1;
         3'h2:    target_next = `PRC_DLY_T2;
         3'h3:    target_next = `PRC_DLY_T3;
         3'h4:    target_next = `PRC_DLY_T4;
         3'h5:    target_next = `PRC_DLY_T5;
         3'h6:    target_next = `PRC_DLY_T6;
         default: target_next = `PRC_DLY_T7;
      endcase
   end

   // The prescaler restarts whenever regulation is lost, so the delay is
   // measured from the moment all grouped rails regulate.
   always @(posedge core_clk_i) begin
      if (rst_i || !in_reg_s) begin
         presc_reg <= 32'h0;
         ticks_reg <= 6'h00;
         good_reg  <= 1'b0;
      end else if (!good_reg) begin
         if (presc_reg == TICK_CYCLES - 32'h1) begin
            presc_reg <= 32'h0;
            ticks_reg <= ticks_reg + 6'h01;
         end else begin
            presc_reg <= presc_reg + 32'h1;
         end
         if (ticks_reg >= target_next)
            good_reg <= 1'b1;
      end
   end

   // Host-driven mode bypasses the delayed power-good on output three; termination enable still waits for it.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         general_output_three_o <= 1'b0;
         termination_enable_o   <= 1'b0;
      end else begin
         general_output_three_o <= otp_out3_pg_mode_i ? good_reg
                                   : general_output_three_host_level_i;
         termination_enable_o   <= otp_out3_vtt_use_i & good_reg;
      end
   end

endmodule // prc_rail_regs

// [test/prc_rail_regs_checker.sv]
`timescale 1ns/1ns
module prc_checker #(
   parameter [31:0] TICK_CYCLES = 32'd10
) (
   input wire        core_clk_i,
   input wire        rst_i,
   input wire        sda_oe_o,
   input wire [71:0] otp_image_i,
   input wire [1:0]  otp_sleep_pin_sel_i,
   input wire        otp_out3_pg_mode_i,
   input wire [11:0] rail_enabled_i,
   input wire        out3_rails_in_reg_i,
   input wire        sleep_pin_first_i,
   input wire        general_output_three_host_level_i,
   input wire [6:0]  rail1_normal_code_i,
   input wire [21:0] discharge_select_o,
   input wire        general_output_three_o,
   input wire        shutdown_trigger_o,
   input wire [6:0]  rail1_target_code_o
);
   // Run length of regulation, saturating so long runs cost nothing.
   reg [31:0] run_reg;
   always @(posedge core_clk_i) begin
      if (rst_i || !out3_rails_in_reg_i) begin
         run_reg <= 32'h0;
      end else if (run_reg < TICK_CYCLES) begin
         run_reg <= run_reg + 32'h1;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   property p_clear;
      rail_enabled_i[2] [*4] |-> discharge_select_o[5:4] == 2'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("Field not cleared.");
   property p_sd_pulse;
      shutdown_trigger_o |=> !shutdown_trigger_o;
   endproperty
   a_sd_pulse: assert property (p_sd_pulse) else $error("Long pulse.");
   property p_sd_quiet;
      shutdown_trigger_o |=> (!sda_oe_o) [*8];
   endproperty
   a_sd_quiet: assert property (p_sd_quiet) else $error("Acked.");
   // The reload shows the image only while no rail holds its field clear.
   property p_sd_reload;
      shutdown_trigger_o && rail_enabled_i == 12'h0 |->
         ##[1:4] discharge_select_o == otp_image_i[21:0];
   endproperty
   a_sd_reload: assert property (p_sd_reload) else $error("No reload.");
   property p_sleep;
      (sleep_pin_first_i && !otp_sleep_pin_sel_i[0]
         && $stable(rail1_normal_code_i)) [*6]
         |-> rail1_target_code_o == rail1_normal_code_i;
   endproperty
   a_sleep: assert property (p_sleep) else $error("Sleep code used.");
   property p_good_wait;
      $rose(general_output_three_o) && otp_out3_pg_mode_i
         |-> run_reg >= TICK_CYCLES;
   endproperty
   a_good_wait: assert property (p_good_wait) else $error("Early.");
   property p_good_drop;
      (!out3_rails_in_reg_i && otp_out3_pg_mode_i) [*6]
         |-> !general_output_three_o;
   endproperty
   a_good_drop: assert property (p_good_drop) else $error("Held.");
   property p_host;
      (!otp_out3_pg_mode_i && $stable(general_output_three_host_level_i)) [*3]
         |-> general_output_three_o == general_output_three_host_level_i;
   endproperty
   a_host: assert property (p_host) else $error("Host level lost.");
   c_shutdown: cover property (shutdown_trigger_o);
   c_good: cover property ($rose(general_output_three_o));
   c_sleep: cover property (rail1_target_code_o != rail1_normal_code_i);
endmodule // prc_checker

bind prc_rail_regs prc_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .sda_oe_o(sda_oe_o),
   .otp_image_i(otp_image_i), .otp_sleep_pin_sel_i(otp_sleep_pin_sel_i),
   .otp_out3_pg_mode_i(otp_out3_pg_mode_i), .rail_enabled_i(rail_enabled_i),
   .out3_rails_in_reg_i(out3_rails_in_reg_i),
   .sleep_pin_first_i(sleep_pin_first_i),
   .general_output_three_host_level_i(general_output_three_host_level_i),
   .rail1_normal_code_i(rail1_normal_code_i),
   .discharge_select_o(discharge_select_o),
   .general_output_three_o(general_output_three_o),
   .shutdown_trigger_o(shutdown_trigger_o),
   .rail1_target_code_o(rail1_target_code_o));

// [test/prc_host_model.sv]
`timescale 1ns/1ns
module prc_host_model #(
   parameter [6:0]   DEV_ADDR = 7'h2a,
   parameter integer HALF     = 10
) (
   input  wire core_clk_i,
   input  wire sda_oe_i,
   output reg  scl_o,
   output wire sda_o
);
   reg low_reg = 1'b0;
   // Open-drain line with a pull-up: released reads high, any puller wins.
   assign sda_o = ~(low_reg | sda_oe_i);
   initial scl_o = 1'b1;
   // All moves happen just after a falling core edge, away from sampling.
   task step(input c, input l, input integer n);
      scl_o = c;
      low_reg = l;
      repeat (n) @(negedge core_clk_i);
   endtask
   // Data is held 4 cycles past the clock fall so the synchroniser agrees.
   task bit_io(input lvl, output smp);
      step(1'b0, ~lvl, HALF);
      step(1'b1, ~lvl, HALF);
      smp = sda_o;
      step(1'b0, ~lvl, 4);
   endtask
   // Also serves as a repeated start when entered with the clock low.
   task start;
      step(scl_o, 1'b0, HALF);
      step(1'b1, 1'b0, HALF);
      step(1'b1, 1'b1, HALF);
      step(1'b0, 1'b1, 4);
   endtask
   task stop;
      step(1'b0, 1'b1, HALF);
      step(1'b1, 1'b1, HALF);
      step(1'b1, 1'b0, HALF);
   endtask
   // Most significant bit first; the ninth slot carries the acknowledge.
   task xfer(input [7:0] tx, input last, output [7:0] rx, output ack);
      integer i;
      reg     s;
      for (i = 7; i >= 0; i = i - 1) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(last, s);
      ack = ~s;
   endtask
   // A refused data byte is handed back, not treated as a bus error.
   task wr(input [7:0] ofs, input [7:0] d, output ack);
      reg [7:0] r;
      start;
      xfer({DEV_ADDR, 1'b0}, 1'b1, r, ack);
      xfer(ofs, 1'b1, r, ack);
      xfer(d, 1'b1, r, ack);
      stop;
   endtask
   task rd(input [7:0] ofs, output [7:0] d);
      reg a;
      start;
      xfer({DEV_ADDR, 1'b0}, 1'b1, d, a);
      xfer(ofs, 1'b1, d, a);
      start;
      xfer({DEV_ADDR, 1'b1}, 1'b1, d, a);
      xfer(8'hff, 1'b1, d, a);
      stop;
   endtask
endmodule // prc_host_model

// [test/prc_testbench.sv]
`timescale 1ns/1ns
module testbench;
   localparam integer TICK = 10;
   localparam [79:0]  OFS  = 80'h96959493929143424140;
   localparam [79:0]  MSK  = 80'hfffeffffff00073fffff;
   localparam [79:0]  DAT  = 80'h9b37d46ac50005e6a93c;
   localparam [71:0]  OTP  = 72'h705b29b5e9fe75599a;
   localparam [47:0]  TKS  = {6'd40, 6'd30, 6'd20, 6'd8, 6'd6, 6'd4, 6'd2, 6'd1};
   reg         core_clk_i;
   reg         rst_i;
   reg  [1:0]  pin_sel;
   reg  [11:0] rail_en;
   reg         pg_mode, in_reg, pin_a, pin_b, host_lvl, ack;
   reg  [7:0]  v;
   wire        scl, sda, sda_oe, out3, vtt, d4, d5;
   wire [21:0] disch;
   wire [6:0]  t1, t2, c4, s4, c5;
   integer     i, fails, comparisons;
   prc_host_model host (.core_clk_i(core_clk_i), .sda_oe_i(sda_oe),
      .scl_o(scl), .sda_o(sda));
   prc_rail_regs #(.TICK_CYCLES(TICK)) dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(), .sda_oe_o(sda_oe), .otp_image_i(OTP),
      .otp_sleep_pin_sel_i(pin_sel), .otp_out3_pg_mode_i(pg_mode),
      .otp_out3_vtt_use_i(1'b1), .rail_enabled_i(rail_en),
      .out3_rails_in_reg_i(in_reg), .sleep_pin_first_i(pin_a),
      .sleep_pin_second_i(pin_b), .general_output_three_host_level_i(host_lvl),
      .rail1_normal_code_i(7'h40), .rail2_normal_code_i(7'h41),
      .discharge_select_o(disch), .general_output_three_o(out3),
      .termination_enable_o(vtt), .shutdown_trigger_o(),
      .rail1_target_code_o(t1), .rail2_target_code_o(t2),
      .rail4_normal_code_o(c4), .rail4_sleep_code_o(s4),
      .rail4_passive_decay_o(d4), .rail5_normal_code_o(c5),
      .rail5_passive_decay_o(d5));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task stop_test;
      if (fails == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
      comparisons = comparisons + 1;
      if (s !== e) begin
         fails = fails + 1;
         $display("ERROR %0s expected %h seen %h", nm, e, s);
      end
   endtask
   task rd_chk(input [7:0] ofs, input [7:0] e);
      host.rd(ofs, v);
      chk("register", e, v);
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge core_clk_i);
   endtask
   // Generous bound: the whole sequence needs roughly half of it.
   initial begin
      repeat (100000) @(posedge core_clk_i);
      fails = fails + 1;
      stop_test;
   end
   initial begin
      {fails, comparisons} = 0;
      {rst_i, pg_mode, pin_a, pin_b, pin_sel} = 6'b111110;
      {rail_en, in_reg, host_lvl} = 0;
      cyc(2);
      rst_i = 1'b0;
      cyc(4);
      // Reset values follow the factory image; reserved bits read zero.
      for (i = 0; i < 10; i = i + 1) rd_chk(OFS[i*8+:8], (i == 4) ? 8'h00 :
         OTP[(i - (i > 4))*8+:8] & MSK[i*8+:8]);
      for (i = 0; i < 10; i = i + 1) if (i != 4) host.wr(OFS[i*8+:8], DAT[i*8+:8], ack);
      for (i = 0; i < 10; i = i + 1) if (i != 4)
         rd_chk(OFS[i*8+:8], DAT[i*8+:8] & MSK[i*8+:8]);
      chk("disch", DAT[21:0], disch);
      chk("rail4", DAT[63:56], {c4, d4});
      chk("rail4slp", DAT[71:65], s4);
      chk("rail5", DAT[79:72], {c5, d5});
      for (i = 0; i < 4; i = i + 1) begin
         host.wr(8'h40, {4{i[1:0]}}, ack);
         chk("codes", {4{i[1:0]}}, disch[7:0]);
      end
      rail_en = 12'h004;
      host.wr(8'h40, 8'hff, ack);
      rd_chk(8'h40, 8'hcf);
      rail_en = 12'h000;
      // Rail one listens to the first pin, rail two to the second.
      host.wr(8'h92, 8'h2b, ack);
      host.wr(8'h93, 8'h57, ack);
      pin_b = 1'b0;
      cyc(6);
      chk("sleep1", 7'h40, t1);
      chk("sleep2", 7'h2b, t2);
      {pin_a, pin_b} = 2'b01;
      cyc(6);
      chk("sleep1", 7'h15, t1);
      host.wr(8'h92, 8'h2a, ack);
      cyc(6);
      chk("sleep1", 7'h40, t1);
      pin_a = 1'b1;
      // Each delay code: still low at its nominal time, high two ticks on.
      for (i = 0; i < 8; i = i + 1) begin
         host.wr(8'h43, i[7:0], ack);
         in_reg = 1'b1;
         cyc(TKS[i*6+:6] * TICK);
         chk("early", 1'b0, out3);
         cyc(2 * TICK + 4);
         chk("good", 2'b11, {out3, vtt});
         in_reg = 1'b0;
         cyc(8);
      end
      host.wr(8'h91, 8'hfe, ack);
      rd_chk(8'h91, 8'h00);
      host.wr(8'h91, 8'h01, ack);
      chk("sd_ack", 1'b0, ack);
      rd_chk(8'h40, OTP[7:0]);
      rd_chk(8'h91, 8'h00);
      rd_chk(8'h50, 8'h00);
      {pg_mode, host_lvl, in_reg, rst_i} = 4'b0111;
      cyc(2);
      rst_i = 1'b0;
      cyc(4);
      chk("host", 1'b1, out3);
      host_lvl = 1'b0;
      cyc(3);
      chk("host", 1'b0, out3);
      stop_test;
   end
endmodule // testbench
